// *** rtl/two_wire_pkg.sv ***
// Constants, field layouts and state types of the two-wire bus master.
// Assumes a single 250 MHz system clock and open-drain pads outside.
// Summary of operation
// - The master itself starts every transfer, drives its clock and ends it.
// - Software loads address, size, dividers, disables slave, enables master first.
// - A transmit holding write starts: START, 7-bit target address, direction 0.
// - During each ninth clock pulse the master releases the data line unless it acknowledges a received byte.
// - An unacknowledged written byte sets no-ack and sends STOP.
// - A status read clears no-ack; software reads before the next write.
// - Every status flag raises the interrupt when its enable is set.
// - On acknowledge, held data moves to the shifter and transmit-ready sets.
// - Transmit-ready doubles as the transmit DMA request.
// - After a written byte the clock stays low until data or STOP.
// - The stop command sends a STOP condition.
// - The start command begins a read: START, 7-bit target address, direction 1.
// - The address acknowledge is sampled; a high line sets no-ack.
// - Every received byte is acknowledged except the last one.
// - Receive-ready sets when a byte lands, clears when the last held byte is read.
// - Receive-ready doubles as the receive DMA request.
// - With the receive store full, the clock stretches before the last bit.
// - A read with internal address writes it first, then repeated START.
// - Up to three internal address bytes; size zero sends none.
// - Each byte is eight bits, most significant first, then an acknowledge.
// - START falls data while clock high; STOP rises data while clock high.
package two_wire_pkg;

  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [15:0] DIV_OFFSET = 16'h0004;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic TRANSMIT_READY_FLAG_RST = 1'b1;
  localparam logic TRANSFER_COMPLETE_FLAG_RST = 1'b1;
  localparam int RX_DEPTH_DEF = 2;
  localparam int IRQ_TRANSFER_COMPLETE_FLAG = 0;
  localparam int IRQ_RECEIVE_READY_FLAG = 1;
  localparam int IRQ_TRANSMIT_READY_FLAG = 2;
  localparam int IRQ_NO_ACK_FLAG = 3;

  typedef struct packed {
    logic [6:0] target_address_field;
    logic read_write_select;
    logic [1:0] internal_address_size;
    logic [23:0] internal_address_bytes;
    logic [2:0] clock_prescale_field;
    logic [7:0] clock_high_divider;
    logic [7:0] clock_low_divider;
  } cfg_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_HOLD,
    ST_RS_LOW, ST_RS_HIGH, ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_END
  } state_e;

  typedef enum logic [1:0] {K_ADDR, K_INTERNAL_ADDRESS_BYTES, K_TXD, K_RXD} kind_e;

endpackage

// *** rtl/two_wire_bus_master.sv ***
// Master engine of the two-wire serial bus: START, address, data, STOP.
// Assumes open-drain pads outside; line inputs are synchronous to i_clk_sys.
`timescale 1ns/1ps
module two_wire_bus_master #(
  parameter int RX_DEPTH = two_wire_pkg::RX_DEPTH_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_master_enable_bit,
  input wire logic i_slave_disable_bit,
  input wire two_wire_pkg::cfg_s i_cfg,
  input wire logic i_start_cmd,
  input wire logic i_stop_cmd,
  input wire logic i_thr_valid,
  input wire logic [7:0] i_thr_data,
  output logic o_transmit_ready_flag,
  output logic [7:0] o_rx_data,
  output logic o_receive_ready_flag,
  input wire logic i_rx_ready,
  input wire logic i_status_read,
  input wire logic [3:0] i_irq_enable,
  output logic o_no_ack_flag,
  output logic o_transfer_complete_flag,
  output logic o_irq,
  output logic o_dma_tx_req,
  output logic o_dma_rx_req,
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe
);
  import two_wire_pkg::*;

  function automatic logic [15:0] phase_len(input logic [7:0] div, input logic [2:0] ps);
    phase_len = ({8'h00, div} << ps) + DIV_OFFSET;
  endfunction

  function automatic logic [7:0] internal_address_bytes_byte(input logic [23:0] ia, input logic [1:0] left);
    internal_address_bytes_byte = (left == 2'h3) ? ia[23:16] : ((left == 2'h2) ? ia[15:8] : ia[7:0]);
  endfunction

  state_e state_ff, nxt_state;
  kind_e kind_ff, nxt_kind;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic [1:0] internal_address_bytes_left_ff, nxt_internal_address_bytes_left;
  logic read_ff, nxt_read;
  logic dir_ff, nxt_dir;
  logic [7:0] thr_ff;
  logic thr_full_ff;
  logic transmit_ready_flag_ff;
  logic stop_req_ff;
  logic no_ack_flag_ff;
  logic transfer_complete_flag_ff;
  logic scl_oe_ff;
  logic sda_oe_ff, nxt_sda_oe;
  logic irq_ff;
  logic line_low_ff;
  logic [7:0] rx_mem_ff [RX_DEPTH];
  logic [7:0] nxt_rx_mem [RX_DEPTH];
  logic [RX_DEPTH-1:0] rx_vld_ff, nxt_rx_vld;

  logic no_ack_flag_set, thr_move, rx_push, transfer_complete_flag_set, stop_enter;

  wire master_on = i_master_enable_bit & i_slave_disable_bit;
  wire idle = (state_ff == ST_IDLE);
  wire thr_take = i_thr_valid & transmit_ready_flag_ff;
  wire write_sel = (i_cfg.read_write_select == DIR_WRITE);
  wire go = idle & master_on & (i_start_cmd | (thr_full_ff & write_sel));
  wire [15:0] t_low = phase_len(i_cfg.clock_low_divider, i_cfg.clock_prescale_field);
  wire [15:0] t_high = phase_len(i_cfg.clock_high_divider, i_cfg.clock_prescale_field);
  wire low_done = (cnt_ff >= t_low - 16'h0001);
  wire high_done = i_scl & (cnt_ff >= t_high - 16'h0001);
  wire is_ack = (bit_ff == ACK_BIT);
  wire rx_full = rx_vld_ff[RX_DEPTH-1];
  wire rx_pop = i_rx_ready & rx_vld_ff[0];
  wire rx_stall = (state_ff == ST_LOW) & (kind_ff == K_RXD) & (bit_ff == LAST_DATA_BIT) & rx_full;
  wire scl_wait = ((state_ff == ST_HIGH) | (state_ff == ST_RS_HIGH) | (state_ff == ST_STOP_HIGH)) & ~i_scl;
  wire hold_cnt = rx_stall | scl_wait;
  wire no_internal_address_bytes = (i_cfg.internal_address_size == 2'h0);
  wire nxt_scl_oe = (nxt_state == ST_LOW) | (nxt_state == ST_HOLD) |
                    (nxt_state == ST_RS_LOW) | (nxt_state == ST_STOP_LOW);
  wire [3:0] irq_src = {no_ack_flag_ff, transmit_ready_flag_ff, o_receive_ready_flag, transfer_complete_flag_ff};

  // Sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_internal_address_bytes_left = internal_address_bytes_left_ff;
    nxt_read = read_ff;
    nxt_dir = dir_ff;
    no_ack_flag_set = 1'b0;
    thr_move = 1'b0;
    rx_push = 1'b0;
    transfer_complete_flag_set = 1'b0;
    stop_enter = 1'b0;
    case (state_ff)
      ST_IDLE:
        if (go)
        begin
          nxt_state = ST_START;
          nxt_read = i_cfg.read_write_select;
          nxt_internal_address_bytes_left = i_cfg.internal_address_size;
          nxt_dir = i_cfg.read_write_select & no_internal_address_bytes;
          nxt_sh = {i_cfg.target_address_field, i_cfg.read_write_select & no_internal_address_bytes};
          nxt_kind = K_ADDR;
        end
      ST_START:
        if (high_done)
        begin
          nxt_state = ST_LOW;
          nxt_bit = 4'h0;
        end
      ST_LOW:
        if (low_done && !rx_stall)
          nxt_state = ST_HIGH;
      ST_HIGH:
        if (high_done)
        begin
          if (!is_ack)
          begin
            nxt_bit = bit_ff + 4'h1;
            nxt_sh = {sh_ff[6:0], i_sda};
            rx_push = (kind_ff == K_RXD) && (bit_ff == LAST_DATA_BIT);
            nxt_state = ST_LOW;
          end
          else if (kind_ff == K_RXD)
          begin
            if (sda_oe_ff)
            begin
              nxt_bit = 4'h0;
              nxt_state = ST_LOW;
            end
            else
              stop_enter = 1'b1;
          end
          else if (i_sda)
          begin
            no_ack_flag_set = 1'b1;
            stop_enter = 1'b1;
          end
          else if (kind_ff == K_ADDR && dir_ff)
          begin
            nxt_kind = K_RXD;
            nxt_bit = 4'h0;
            nxt_state = ST_LOW;
          end
          else if (internal_address_bytes_left_ff != 2'h0)
          begin
            nxt_kind = K_INTERNAL_ADDRESS_BYTES;
            nxt_sh = internal_address_bytes_byte(i_cfg.internal_address_bytes, internal_address_bytes_left_ff);
            nxt_internal_address_bytes_left = internal_address_bytes_left_ff - 2'h1;
            nxt_bit = 4'h0;
            nxt_state = ST_LOW;
          end
          else if (read_ff)
          begin
            nxt_state = ST_RS_LOW;
            nxt_kind = K_ADDR;
            nxt_dir = DIR_READ;
            nxt_sh = {i_cfg.target_address_field, DIR_READ};
          end
          else
            nxt_state = ST_HOLD;
        end
      ST_HOLD:
        if (thr_full_ff)
        begin
          thr_move = 1'b1;
          nxt_sh = thr_ff;
          nxt_kind = K_TXD;
          nxt_bit = 4'h0;
          nxt_state = ST_LOW;
        end
        else if (stop_req_ff)
          stop_enter = 1'b1;
      ST_RS_LOW:
        if (low_done)
          nxt_state = ST_RS_HIGH;
      ST_RS_HIGH:
        if (high_done)
          nxt_state = ST_START;
      ST_STOP_LOW:
        if (low_done)
          nxt_state = ST_STOP_HIGH;
      ST_STOP_HIGH:
        if (high_done)
          nxt_state = ST_STOP_END;
      ST_STOP_END:
        if (high_done)
        begin
          nxt_state = ST_IDLE;
          transfer_complete_flag_set = 1'b1;
        end
      default:
        nxt_state = ST_IDLE;
    endcase
    if (stop_enter)
      nxt_state = ST_STOP_LOW;
  end

  // Data line drive, changed one cycle after the clock line falls, except at START and STOP
  always_comb
  begin
    nxt_sda_oe = sda_oe_ff;
    case (state_ff)
      ST_IDLE:
        nxt_sda_oe = 1'b0;
      ST_START:
        nxt_sda_oe = 1'b1;
      ST_LOW:
        if (is_ack)
          nxt_sda_oe = (kind_ff == K_RXD) & ~stop_req_ff;
        else
          nxt_sda_oe = (kind_ff != K_RXD) & ~sh_ff[7];
      ST_RS_LOW, ST_RS_HIGH:
        nxt_sda_oe = 1'b0;
      ST_STOP_LOW, ST_STOP_HIGH:
        nxt_sda_oe = 1'b1;
      ST_STOP_END:
        nxt_sda_oe = 1'b0;
      default:
        nxt_sda_oe = sda_oe_ff;
    endcase
  end

  assign nxt_cnt = ((nxt_state != state_ff) || hold_cnt) ? 16'h0000 : cnt_ff + 16'h0001;

  // Receive buffer: head at entry 0, shifts on pop
  always_comb
  begin
    logic placed;
    placed = 1'b0;
    nxt_rx_mem = rx_mem_ff;
    nxt_rx_vld = rx_vld_ff;
    if (rx_pop)
    begin
      for (int i = 0; i < RX_DEPTH - 1; i++)
      begin
        nxt_rx_mem[i] = rx_mem_ff[i+1];
        nxt_rx_vld[i] = rx_vld_ff[i+1];
      end
      nxt_rx_vld[RX_DEPTH-1] = 1'b0;
    end
    if (rx_push)
    begin
      for (int i = 0; i < RX_DEPTH; i++)
      begin
        if (!nxt_rx_vld[i] && !placed)
        begin
          nxt_rx_mem[i] = {sh_ff[6:0], i_sda};
          nxt_rx_vld[i] = 1'b1;
          placed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_ff <= ST_IDLE;
      kind_ff <= K_ADDR;
      cnt_ff <= 16'h0000;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      internal_address_bytes_left_ff <= 2'h0;
      read_ff <= 1'b0;
      dir_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      internal_address_bytes_left_ff <= nxt_internal_address_bytes_left;
      read_ff <= nxt_read;
      dir_ff <= nxt_dir;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      thr_ff <= 8'h00;
      thr_full_ff <= 1'b0;
      transmit_ready_flag_ff <= TRANSMIT_READY_FLAG_RST;
      stop_req_ff <= 1'b0;
      no_ack_flag_ff <= 1'b0;
      transfer_complete_flag_ff <= TRANSFER_COMPLETE_FLAG_RST;
    end
    else
    begin
      if (thr_take)
        thr_ff <= i_thr_data;
      thr_full_ff <= thr_take | (thr_full_ff & ~thr_move & ~no_ack_flag_set);
      transmit_ready_flag_ff <= thr_take ? 1'b0 : (thr_move | no_ack_flag_set | transmit_ready_flag_ff);
      stop_req_ff <= i_stop_cmd | (stop_req_ff & ~stop_enter & ~(idle & ~go));
      no_ack_flag_ff <= no_ack_flag_set | (no_ack_flag_ff & ~i_status_read);
      transfer_complete_flag_ff <= transfer_complete_flag_set | (transfer_complete_flag_ff & ~go);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      rx_vld_ff <= '0;
      for (int i = 0; i < RX_DEPTH; i++)
        rx_mem_ff[i] <= 8'h00;
    end
    else
    begin
      rx_vld_ff <= nxt_rx_vld;
      rx_mem_ff <= nxt_rx_mem;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      irq_ff <= 1'b0;
      line_low_ff <= 1'b0;
    end
    else
    begin
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      irq_ff <= |(irq_src & i_irq_enable);
      line_low_ff <= 1'b0;
    end
  end

  assign o_transmit_ready_flag = transmit_ready_flag_ff;
  assign o_dma_tx_req = transmit_ready_flag_ff;
  assign o_rx_data = rx_mem_ff[0];
  assign o_receive_ready_flag = rx_vld_ff[0];
  assign o_dma_rx_req = rx_vld_ff[0];
  assign o_no_ack_flag = no_ack_flag_ff;
  assign o_transfer_complete_flag = transfer_complete_flag_ff;
  assign o_irq = irq_ff;
  assign o_scl_o = line_low_ff;
  assign o_scl_oe = scl_oe_ff;
  assign o_sda_o = line_low_ff;
  assign o_sda_oe = sda_oe_ff;

endmodule // two_wire_bus_master

// *** verif/two_wire_bus_master_assertions.sv ***
// Port-level checker for the two-wire bus master.
// Assumes the single system clock and its synchronous reset.
`timescale 1ns/1ps
module two_wire_bus_master_assertions (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_master_enable_bit,
  input wire logic i_slave_disable_bit,
  input wire logic i_thr_valid,
  input wire logic i_rx_ready,
  input wire logic i_status_read,
  input wire logic [3:0] i_irq_enable,
  input wire logic i_scl,
  input wire logic o_transmit_ready_flag,
  input wire logic o_receive_ready_flag,
  input wire logic o_no_ack_flag,
  input wire logic o_transfer_complete_flag,
  input wire logic o_irq,
  input wire logic o_dma_tx_req,
  input wire logic o_dma_rx_req,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire logic irq_src = |({o_no_ack_flag, o_transmit_ready_flag, o_receive_ready_flag, o_transfer_complete_flag}
    & i_irq_enable);
  wire logic off = !(i_master_enable_bit && i_slave_disable_bit);
  property p_tx_dma; o_dma_tx_req == o_transmit_ready_flag; endproperty
  property p_rx_dma; o_dma_rx_req == o_receive_ready_flag; endproperty
  property p_tx_take; i_thr_valid && o_transmit_ready_flag |=> !o_transmit_ready_flag; endproperty
  property p_start_cond; $rose(o_sda_oe) && !o_scl_oe |-> i_scl; endproperty
  property p_stop_cond; $fell(o_sda_oe) && !o_scl_oe |-> i_scl ##[0:40] o_transfer_complete_flag; endproperty
  property p_no_ack_flag_stop; $rose(o_no_ack_flag) |-> ##[1:80] ($fell(o_sda_oe) && !o_scl_oe); endproperty
  property p_irq; !$past(i_reset) |-> o_irq == $past(irq_src); endproperty
  property p_no_ack_flag_clear; o_no_ack_flag && i_status_read |=> !o_no_ack_flag; endproperty
  property p_reset_vals; $fell(i_reset) |-> !o_scl_oe && !o_sda_oe && o_transmit_ready_flag
    && o_transfer_complete_flag && !o_no_ack_flag && !o_receive_ready_flag; endproperty
  property p_start_gate; off && o_transfer_complete_flag && !o_sda_oe && !o_scl_oe |=> !o_sda_oe; endproperty
  a_tx_dma: assert property (p_tx_dma) else $error("tx request differs from tx ready");
  a_rx_dma: assert property (p_rx_dma) else $error("rx request differs from rx ready");
  a_tx_take: assert property (p_tx_take) else $error("tx ready kept after write");
  a_start_cond: assert property (p_start_cond) else $error("start without clock high");
  a_stop_cond: assert property (p_stop_cond) else $error("bad stop condition");
  a_no_ack_flag_stop: assert property (p_no_ack_flag_stop) else $error("no stop after no-ack");
  a_irq: assert property (p_irq) else $error("irq mismatch");
  a_no_ack_flag_clear: assert property (p_no_ack_flag_clear) else $error("no-ack not cleared");
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
  a_start_gate: assert property (p_start_gate) else $error("start while disabled");
  c_no_ack_flag: cover property ($rose(o_no_ack_flag));
  c_pop: cover property (o_receive_ready_flag && i_rx_ready);
  c_take: cover property ($fell(o_transmit_ready_flag));
endmodule // two_wire_bus_master_assertions
bind two_wire_bus_master two_wire_bus_master_assertions u_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_master_enable_bit(i_master_enable_bit), .i_slave_disable_bit(i_slave_disable_bit),
  .i_thr_valid(i_thr_valid), .i_rx_ready(i_rx_ready), .i_status_read(i_status_read),
  .i_irq_enable(i_irq_enable), .i_scl(i_scl), .o_transmit_ready_flag(o_transmit_ready_flag),
  .o_receive_ready_flag(o_receive_ready_flag), .o_no_ack_flag(o_no_ack_flag),
  .o_transfer_complete_flag(o_transfer_complete_flag), .o_irq(o_irq), .o_dma_tx_req(o_dma_tx_req),
  .o_dma_rx_req(o_dma_rx_req), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe));

// *** verif/two_wire_slave_model.sv ***
// Behavioural bus slave: acks bytes, sends counting bytes on reads.
// Assumes resolved wired-AND lines sampled on the system clock.
`timescale 1ns/1ps
module two_wire_slave_model #(
  parameter logic [7:0] TX_BASE = 8'hc3
) (
  input wire logic i_clk_sys,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_no_ack_flag,
  output logic o_sda_oe,
  output logic o_stb,
  output logic [7:0] o_byte
);
  logic ps = 1'b1, pd = 1'b1, rd = 1'b0, tx = 1'b0, act = 1'b0, adr = 1'b0;
  logic [3:0] bc = 4'h0;
  logic [7:0] sr = 8'h00, tb = 8'h00, cnt = TX_BASE;
  initial o_sda_oe = 1'b0;
  initial o_stb = 1'b0;
  initial o_byte = 8'h00;
  always @(posedge i_clk_sys)
  begin
    ps <= i_scl;
    pd <= i_sda;
    o_stb <= 1'b0;
    if (i_scl && ps && pd && !i_sda)
    begin
      bc <= 4'h0; tx <= 1'b0; act <= 1'b1; adr <= 1'b1; o_sda_oe <= 1'b0;
    end
    else if (i_scl && ps && !pd && i_sda)
    begin
      act <= 1'b0; tx <= 1'b0; o_sda_oe <= 1'b0;
    end
    else if (act && i_scl && !ps)
    begin
      bc <= bc + 4'h1;
      sr <= {sr[6:0], i_sda};
      if (bc == 4'h7 && !tx)
      begin
        o_stb <= 1'b1; o_byte <= {sr[6:0], i_sda}; rd <= i_sda;
      end
      if (bc == 4'h8 && tx)
      begin
        o_stb <= 1'b1; o_byte <= {7'h00, i_sda}; act <= !i_sda;
      end
    end
    else if (act && !i_scl && ps)
    begin
      if (bc == 4'h8) o_sda_oe <= !tx && !i_no_ack_flag;
      else if (bc == 4'h9)
      begin
        bc <= 4'h0;
        adr <= 1'b0;
        if ((adr && rd && !i_no_ack_flag) || tx)
        begin
          tx <= 1'b1; tb <= cnt; cnt <= cnt + 8'h01; o_sda_oe <= !cnt[7];
        end
        else o_sda_oe <= 1'b0;
      end
      else if (tx) o_sda_oe <= !tb[7 - bc];
    end
  end
endmodule // two_wire_slave_model

// *** verif/two_wire_bus_master_tb.sv ***
// Self-checking bench: writes, reads, stretching and no-ack.
// Assumes the slave model and the bound checker.
`timescale 1ns/1ps
module two_wire_bus_master_tb;
  import two_wire_pkg::*;
  logic clk = 0, rst = 1, men = 0, sdis = 1, st = 0, sp = 0, tv = 0, rxr = 0, srd = 0, no_ack_flag = 0;
  logic [7:0] td = 8'h00, rxd, sbyte, rb = 8'hc3;
  logic [3:0] ien = 4'h0;
  logic [31:0] a, ia;
  cfg_s cfg = '0;
  logic txr, rrdy, nak, tc, irq, sclo, scl_oe, sdao, sda_oe, slv_oe, stb;
  wire logic scl = !scl_oe || sclo;
  wire logic sda = (!sda_oe || sdao) && !slv_oe;
  int n_mismatch = 0, num_checks = 0, sz, k;
  logic [7:0] exp_q[$], rx_q[$];
  always #2 clk = ~clk;
  two_wire_bus_master dut (.i_clk_sys(clk), .i_reset(rst), .i_master_enable_bit(men),
    .i_slave_disable_bit(sdis), .i_cfg(cfg), .i_start_cmd(st), .i_stop_cmd(sp), .i_thr_valid(tv),
    .i_thr_data(td), .o_transmit_ready_flag(txr), .o_rx_data(rxd), .o_receive_ready_flag(rrdy),
    .i_rx_ready(rxr), .i_status_read(srd), .i_irq_enable(ien), .o_no_ack_flag(nak),
    .o_transfer_complete_flag(tc), .o_irq(irq), .o_dma_tx_req(), .o_dma_rx_req(), .i_scl(scl),
    .o_scl_o(sclo), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(sdao), .o_sda_oe(sda_oe));
  two_wire_slave_model slv (.i_clk_sys(clk), .i_scl(scl), .i_sda(sda), .i_no_ack_flag(no_ack_flag),
    .o_sda_oe(slv_oe), .o_stb(stb), .o_byte(sbyte));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wait_on(input int w);
    for (int i = 0; i < 4000; i++)
    begin
      @(negedge clk);
      if ((w == 0 && txr === 1'b1) || (w == 1 && rrdy === 1'b1) || (w == 2 && tc === 1'b1)) return;
    end
    chk(8'(w), 8'hff);
    close_out();
  endtask
  task thr_write(input logic [7:0] b);
    wait_on(0);
    td = b;
    tv = 1;
    @(negedge clk);
    tv = 0;
  endtask
  task pulse(input logic s, input logic p);
    @(negedge clk);
    st = s; sp = p;
    @(negedge clk);
    st = 0; sp = 0;
  endtask
  task low_len(input logic [15:0] exp);
    int n;
    n = 0;
    for (int i = 0; i < 200 && scl_oe !== 1'b1; i++) @(negedge clk);
    for (int i = 0; i < 200 && scl_oe === 1'b1; i++)
    begin
      n++;
      @(negedge clk);
    end
    chk(8'(n), exp[7:0]);
  endtask
  always @(posedge clk)
  begin
    if (stb === 1'b1) chk(sbyte, exp_q.size() ? exp_q.pop_front() : ~sbyte);
    if (rrdy === 1'b1 && rxr === 1'b1) chk(rxd, rx_q.size() ? rx_q.pop_front() : ~rxd);
  end
  initial
  begin
    void'($urandom(7));
    cfg.clock_low_divider = 8'h02;
    cfg.clock_high_divider = 8'h02;
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 0;
    pulse(1, 0);
    repeat (60) @(negedge clk);
    chk({7'h00, tc}, 8'h01);
    men = 1; sdis = 0;
    pulse(1, 0);
    repeat (60) @(negedge clk);
    chk({7'h00, tc}, 8'h01);
    sdis = 1;
    for (sz = 0; sz < 4; sz++)
    begin
      a = $urandom; ia = $urandom;
      cfg.target_address_field = a[6:0]; cfg.read_write_select = 0;
      cfg.internal_address_size = sz[1:0]; cfg.internal_address_bytes = ia[23:0];
      exp_q.push_back({a[6:0], 1'b0});
      for (k = sz; k > 0; k--) exp_q.push_back(ia[8*k-1 -: 8]);
      exp_q.push_back(a[15:8]); exp_q.push_back(a[23:16]);
      thr_write(a[15:8]);
      thr_write(a[23:16]);
      repeat (400) @(negedge clk);
      chk({7'h00, scl_oe}, 8'h01);
      chk(8'(exp_q.size()), 8'h00);
      pulse(0, 1);
      wait_on(2);
      chk({7'h00, nak}, 8'h00);
    end
    a = $urandom;
    cfg.target_address_field = {5'h1e, a[1:0]}; cfg.read_write_select = 1;
    cfg.internal_address_size = 2'h1; cfg.internal_address_bytes = {16'h0000, a[15:8]};
    exp_q = '{{5'h1e, a[1:0], 1'b0}, a[15:8], {5'h1e, a[1:0], 1'b1}, 8'h00, 8'h00, 8'h01};
    rx_q = '{rb, rb + 8'h01, rb + 8'h02};
    rb = rb + 8'h04;
    pulse(1, 0);
    wait_on(1);
    repeat (600) @(negedge clk);
    chk({6'h00, scl_oe, rrdy}, 8'h03);
    chk(8'(exp_q.size()), 8'h01);
    pulse(0, 1);
    rxr = 1;
    wait_on(2);
    @(negedge clk) rxr = 0;
    cfg.internal_address_size = 2'h0;
    exp_q = '{{5'h1e, a[1:0], 1'b1}, 8'h01};
    rx_q = '{rb - 8'h01};
    pulse(1, 1);
    rxr = 1;
    wait_on(2);
    @(negedge clk) rxr = 0;
    chk(8'(exp_q.size() + rx_q.size()), 8'h00);
    cfg.read_write_select = 0;
    cfg.clock_prescale_field = 3'h1; cfg.clock_low_divider = {6'h00, a[1:0]} + 8'h01;
    exp_q = '{{5'h1e, a[1:0], 1'b0}, a[7:0], a[31:24]};
    thr_write(a[7:0]);
    low_len({7'h00, cfg.clock_low_divider, 1'b0} + DIV_OFFSET);
    wait_on(0);
    pulse(0, 1);
    thr_write(a[31:24]);
    wait_on(2);
    chk(8'(exp_q.size()), 8'h00);
    no_ack_flag = 1; ien = 4'h8;
    for (k = 0; k < 2; k++)
    begin
      cfg.read_write_select = k[0];
      exp_q.push_back({5'h1e, a[1:0], k[0]});
      if (k == 0) thr_write(a[31:24]);
      else pulse(1, 0);
      repeat (20) @(negedge clk);
      wait_on(2);
      chk({6'h00, nak, irq}, 8'h03);
      srd = 1;
      @(negedge clk) srd = 0;
      @(negedge clk);
      chk({6'h00, nak, irq}, 8'h00);
    end
    close_out();
  end
endmodule // two_wire_bus_master_tb
